// [sdi_chan_ctrl.v]
/*
 * per-channel control and status for an sdi demo transmitter/receiver:
 * register port, format/pattern selection, transceiver reset requests,
 * line-drive enable, change status, receive status and error count.
 * assumes datapath status inputs come from other clock domains and are
 * synchronised here; reset requests are consumed by a transceiver reset
 * controller that reports done/fail back.
 */
// Added by the designer: the placing of the registers and the strobed register port.
// Behaviour
// - mode, rate, format code select transmit format
// - fractional hd, 3g and sd code validity
// - hd/3g pattern codes: bars, checkfield, 75 bars
// - sd pattern codes: sd bars or checkfield
// - drive enable zero turns transmitter off
// - drive enable one: transmit, receiver stays on
// - full reset hits channel pll and transmitter
// - plain reset hits transmitter only
// - status shows last sequence done or failure code
// - signal type sd, hd, 3g a, 3g b
// - rx format describes transport structure
// - error count cleared by request or bit-rate change
`timescale 1ns/1ps
`include "sdi_ctrl_defs.vh"
module sdi_chan_ctrl
#(
   parameter ERR_W = 16
)
(
   input  wire             clk_in,
   input  wire             reset_in,
   // register port
   input  wire [7:0]       addr_in,
   input  wire [31:0]      wdata_in,
   input  wire             wr_in,
   input  wire             rd_in,
   output reg  [31:0]      rdata_out,
   output reg              irq_out,
   // transmit side
   output reg  [1:0]       tx_mode_out,
   output reg              tx_rate_out,
   output reg  [2:0]       tx_fmt_out,
   output reg  [1:0]       tx_pattern_out,
   output reg              tx_drive_en_out,
   output reg              rx_enable_out,
   output reg              channel_pll_reset_out,
   output reg              tx_unit_reset_out,
   input  wire             tx_change_done_in,
   input  wire             tx_change_fail_in,
   input  wire [2:0]       tx_fail_code_in,
   // receive side
   input  wire             rx_locked_in,
   input  wire [1:0]       rx_sig_type_in,
   input  wire             rx_rate_in,
   input  wire [3:0]       rx_xport_fmt_in,
   input  wire [3:0]       rx_xport_rate_in,
   input  wire             rx_crc_err_in
);

   ////////////////////////////////////////////////////////////////////////
   // synchronisers for inputs from other domains

   reg  [17:0] sync1_q;
   reg  [17:0] sync2_q;
   wire [17:0] async_in = {tx_change_done_in, tx_change_fail_in, tx_fail_code_in,
                           rx_locked_in, rx_sig_type_in, rx_rate_in, rx_xport_fmt_in,
                           rx_xport_rate_in, rx_crc_err_in};

   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sync1_q <= 18'h00000;
         sync2_q <= 18'h00000;
      end
      else
      begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   // multi-bit fields are quasi-static status; a torn sample lasts one cycle
   wire       s_done      = sync2_q[17];
   wire       s_fail      = sync2_q[16];
   wire [2:0] s_code      = sync2_q[15:13];
   wire       s_locked    = sync2_q[12];
   wire [1:0] s_sig_type  = sync2_q[11:10];
   wire       s_rate      = sync2_q[9];
   wire [3:0] s_xfmt      = sync2_q[8:5];
   wire [3:0] s_xrate     = sync2_q[4:1];
   wire       s_crc       = sync2_q[0];

   ////////////////////////////////////////////////////////////////////////
   // control register and format selection

   reg  [31:0] tx_ctrl_q;
   reg  [3:0]  irq_stat_q;
   reg  [3:0]  irq_mask_q;
   reg  [ERR_W-1:0] err_cnt_q;
   reg         bad_fmt_q;
   reg         done_q;
   reg         fail_q;
   reg         locked_q;
   reg         rate_q;
   reg         full_req_q;
   reg         tx_req_q;

   wire        fmt_valid;
   wire [1:0]  pattern_sel;
   wire        full_pulse;
   wire        tx_pulse;

   // one strobe aimed at one register offset
   function reg_hit;
      input       strobe;
      input [7:0] addr;
      input [7:0] offset;
   begin
      reg_hit = strobe && addr == offset;
   end
   endfunction

   wire wr_ctrl  = reg_hit(wr_in, addr_in, `REG_TX_CTRL);
   wire wr_reset = reg_hit(wr_in, addr_in, `REG_RESET_REQ);
   wire wr_stat  = reg_hit(wr_in, addr_in, `REG_IRQ_STATUS);
   wire wr_mask  = reg_hit(wr_in, addr_in, `REG_IRQ_MASK);

   // control fields as stored; the format and pattern outputs copy them only when valid, drive enable always
   wire [1:0] ctrl_mode  = tx_ctrl_q[`TXC_MODE_LSB+1:`TXC_MODE_LSB];
   wire       ctrl_rate  = tx_ctrl_q[`TXC_RATE_BIT];
   wire [2:0] ctrl_fmt   = tx_ctrl_q[`TXC_FMT_LSB+2:`TXC_FMT_LSB];
   wire [1:0] ctrl_pat   = tx_ctrl_q[`TXC_PAT_LSB+1:`TXC_PAT_LSB];
   wire       ctrl_drive = tx_ctrl_q[`TXC_DRIVE_BIT];

   fmt_select u_fmt
   (
      .mode_in     (ctrl_mode),
      .rate_in     (ctrl_rate),
      .fmt_in      (ctrl_fmt),
      .pat_in      (ctrl_pat),
      .valid_out   (fmt_valid),
      .pattern_out (pattern_sel)
   );

   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         tx_ctrl_q       <= `TXC_RESET;
         tx_mode_out     <= `MODE_HD;
         tx_rate_out     <= 1'b0;
         tx_fmt_out      <= 3'h0;
         tx_pattern_out  <= `PAT_BARS_FULL;
         tx_drive_en_out <= 1'b0;
         rx_enable_out   <= 1'b1;
         bad_fmt_q       <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            tx_ctrl_q <= wdata_in;
         // only valid combinations reach the pattern generator
         if (fmt_valid)
         begin
            tx_mode_out    <= ctrl_mode;
            tx_rate_out    <= ctrl_rate;
            tx_fmt_out     <= ctrl_fmt;
            tx_pattern_out <= pattern_sel;
         end
         // high while the stored combination is invalid
         bad_fmt_q       <= !fmt_valid;
         tx_drive_en_out <= ctrl_drive;
         // the receiver listens even while the channel drives the line
         rx_enable_out   <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transceiver reset requests

   // requests are registered so the stretchers see a clean one-cycle trigger
   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         full_req_q <= 1'b0;
         tx_req_q   <= 1'b0;
         channel_pll_reset_out <= 1'b0;
         tx_unit_reset_out     <= 1'b0;
      end
      else
      begin
         full_req_q <= wr_reset && wdata_in[`RST_FULL_BIT];
         tx_req_q   <= wr_reset && wdata_in[`RST_TX_BIT];
         channel_pll_reset_out <= full_pulse;
         tx_unit_reset_out     <= full_pulse || tx_pulse;
      end
   end

   pulse_stretch u_full
   (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .trig_in   (full_req_q),
      .pulse_out (full_pulse)
   );

   pulse_stretch u_tx
   (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .trig_in   (tx_req_q),
      .pulse_out (tx_pulse)
   );

   ////////////////////////////////////////////////////////////////////////
   // receive error counter and event flags

   // a bit-rate change means relock, so the count restarts
   wire err_clr   = wr_reset && wdata_in[`RST_ERRCLR_BIT];
   wire rate_chg  = s_rate != rate_q;
   wire lock_lost = locked_q && !s_locked;

   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         err_cnt_q <= {ERR_W{1'b0}};
         done_q    <= 1'b0;
         fail_q    <= 1'b0;
         locked_q  <= 1'b0;
         rate_q    <= 1'b0;
      end
      else
      begin
         done_q   <= s_done;
         fail_q   <= s_fail;
         locked_q <= s_locked;
         rate_q   <= s_rate;
         if (err_clr || rate_chg)
            err_cnt_q <= {ERR_W{1'b0}};
         // saturate rather than wrap
         else if (s_crc && err_cnt_q != {ERR_W{1'b1}})
            err_cnt_q <= err_cnt_q + {{(ERR_W-1){1'b0}}, 1'b1};
      end
   end

   // events are edges: done, fail, entering an invalid format, lock lost
   wire [3:0] irq_evt = {lock_lost, (!fmt_valid && !bad_fmt_q),
                         (s_fail && !fail_q), (s_done && !done_q)};

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, mask, read port

   // status words as software reads them
   wire [31:0] tx_status_word = {26'h0, bad_fmt_q, s_code, s_fail, s_done};
   wire [31:0] rx_status_word = {16'h0, s_xrate, s_xfmt, 3'h0, s_rate,
                                 s_sig_type, 1'b0, s_locked};

   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
         irq_out    <= 1'b0;
      end
      else
      begin
         // a new event wins over a write-one clear
         if (wr_stat)
            irq_stat_q <= (irq_stat_q & ~wdata_in[3:0]) | irq_evt;
         else
            irq_stat_q <= irq_stat_q | irq_evt;
         if (wr_mask)
            irq_mask_q <= wdata_in[3:0];
         irq_out <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read data stand for the one cycle after the strobe, zero otherwise
   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         rdata_out <= 32'h0000_0000;
      end
      else
      begin
         rdata_out <= 32'h0000_0000;
         if (rd_in)
         begin
            case (addr_in)
               `REG_TX_CTRL:    rdata_out <= tx_ctrl_q;
               `REG_TX_STATUS:  rdata_out <= tx_status_word;
               `REG_RX_STATUS:  rdata_out <= rx_status_word;
               `REG_RX_ERRCNT:  rdata_out <= {{(32-ERR_W){1'b0}}, err_cnt_q};
               `REG_IRQ_STATUS: rdata_out <= {28'h0, irq_stat_q};
               `REG_IRQ_MASK:   rdata_out <= {28'h0, irq_mask_q};
               default:         rdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

// [sdi_ctrl_defs.vh]
/*
 * constants for the sdi channel control block: register offsets, field
 * positions, reset values, mode and pattern codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef SDI_CTRL_DEFS_VH
`define SDI_CTRL_DEFS_VH

// register offsets (byte addresses, one 32-bit word each)
`define REG_TX_CTRL     8'h00
`define REG_TX_STATUS   8'h04
`define REG_RX_STATUS   8'h08
`define REG_RX_ERRCNT   8'h0c
`define REG_IRQ_STATUS  8'h10
`define REG_IRQ_MASK    8'h14
`define REG_RESET_REQ   8'h18

// tx_ctrl fields
`define TXC_FMT_LSB     0
`define TXC_PAT_LSB     4
`define TXC_RATE_BIT    8
`define TXC_MODE_LSB    12
`define TXC_DRIVE_BIT   16
`define TXC_RESET       32'h0000_0000

// reset_req fields (write one to request)
`define RST_FULL_BIT    0
`define RST_TX_BIT      1
`define RST_ERRCLR_BIT  2

// irq bits
`define IRQ_TX_DONE     0
`define IRQ_TX_FAIL     1
`define IRQ_BAD_FMT     2
`define IRQ_RX_LOCK     3
`define IRQ_WIDTH       4

// sdi modes
`define MODE_HD         2'h0
`define MODE_SD         2'h1
`define MODE_3G         2'h2

// signal types reported by the receiver
`define SIG_SD          2'h0
`define SIG_HD          2'h1
`define SIG_3GA         2'h2
`define SIG_3GB         2'h3

// patterns
`define PAT_BARS_FULL   2'h0
`define PAT_CHECKFIELD  2'h1
`define PAT_BARS_75     2'h2
`define PAT_BARS_SD     2'h3

// reset pulse length in cycles
`define RESET_PULSE     8'h10

`endif

// [fmt_select.v]
/*
 * format and pattern decoder: maps mode, rate and format code onto a
 * validity flag, and the pattern code onto a pattern.
 * assumes registered inputs on the same clock.
 */
`timescale 1ns/1ps
`include "sdi_ctrl_defs.vh"
module fmt_select
(
   input  wire [1:0] mode_in,
   input  wire       rate_in,
   input  wire [2:0] fmt_in,
   input  wire [1:0] pat_in,
   output reg        valid_out,
   output reg  [1:0] pattern_out
);

   always @*
   begin
      case (mode_in)
         `MODE_HD:
            // fractional rate allows codes 1,2,4,6,7 only
            valid_out = !rate_in || fmt_in == 3'h1 || fmt_in == 3'h2 || fmt_in == 3'h4 ||
                        fmt_in == 3'h6 || fmt_in == 3'h7;
         `MODE_3G:
            valid_out = fmt_in == 3'h4 || (fmt_in == 3'h5 && !rate_in);
         `MODE_SD:
            valid_out = 1'b1;  // even ntsc, odd pal
         default:
            valid_out = 1'b0;
      endcase
      if (mode_in == `MODE_SD)
      begin
         pattern_out = pat_in[0] ? `PAT_CHECKFIELD : `PAT_BARS_SD;
      end
      else
      begin
         case (pat_in)
            2'h0:    pattern_out = `PAT_BARS_FULL;
            2'h2:    pattern_out = `PAT_BARS_75;
            default: pattern_out = `PAT_CHECKFIELD;
         endcase
      end
   end

endmodule

// [pulse_stretch.v]
/*
 * stretches a one-cycle request into a reset pulse of fixed length.
 * assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`include "sdi_ctrl_defs.vh"
module pulse_stretch
(
   input  wire clk_in,
   input  wire reset_in,
   input  wire trig_in,
   output reg  pulse_out
);

   reg [7:0] cnt_q;

   always @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         cnt_q     <= 8'h00;
         pulse_out <= 1'b0;
      end
      else
      begin
         if (trig_in)
            cnt_q <= `RESET_PULSE;
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
         pulse_out <= trig_in || cnt_q > 8'h01;
      end
   end

endmodule

// [sdi_chan_ctrl_checker.sv]
/* port checker for sdi_chan_ctrl.
   assumes the shared header constants and one clock domain. */
`timescale 1ns/1ps
`include "sdi_ctrl_defs.vh"
module sdi_chan_ctrl_checker
(
   input wire        clk_in,
   input wire        reset_in,
   input wire [7:0]  addr_in,
   input wire [31:0] wdata_in,
   input wire        wr_in,
   input wire        rd_in,
   input wire [31:0] rdata_out,
   input wire [1:0]  tx_mode_out,
   input wire        tx_rate_out,
   input wire [2:0]  tx_fmt_out,
   input wire [1:0]  tx_pattern_out,
   input wire        tx_drive_en_out,
   input wire        rx_enable_out,
   input wire        channel_pll_reset_out,
   input wire        tx_unit_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire rst_wr = wr_in && addr_in == `REG_RESET_REQ && !tx_unit_reset_out;
   ////////////////////////////////////////////////////////////////////////
   chk_rd_quiet:
      assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("rdata not idle");
   chk_rx_alive:
      assert property (rx_enable_out) else $error("receiver disabled");
   chk_full_req:
      assert property (rst_wr && wdata_in[0] |-> ##3 (channel_pll_reset_out && tx_unit_reset_out))
      else $error("full reset missing");
   chk_pll_pulse:
      assert property ($rose(channel_pll_reset_out) |-> channel_pll_reset_out[*8])
      else $error("pll reset too short");
   chk_plain_only:
      assert property (rst_wr && wdata_in[1:0] == 2'h2 |-> ##3 (tx_unit_reset_out
         && !channel_pll_reset_out)) else $error("plain reset wrong");
   chk_tx_cause:
      assert property ($changed({tx_mode_out, tx_rate_out, tx_fmt_out, tx_pattern_out})
         |-> $past(wr_in, 2) && $past(addr_in, 2) == `REG_TX_CTRL) else $error("tx moved");
   chk_drive_src:
      assert property ($changed(tx_drive_en_out) |-> tx_drive_en_out == $past(wdata_in[16], 2))
      else $error("drive enable wrong");
   chk_mode_ok:
      assert property (tx_mode_out != 2'h3) else $error("bad mode out");
   chk_sd_pat:
      assert property (tx_mode_out == `MODE_SD |-> tx_pattern_out[0]) else $error("sd pattern");
   chk_hd_pat:
      assert property (tx_mode_out != `MODE_SD |-> tx_pattern_out != `PAT_BARS_SD)
      else $error("hd pattern");
   chk_fmt_3g:
      assert property (tx_mode_out == `MODE_3G |-> tx_fmt_out == 3'h4
         || (tx_fmt_out == 3'h5 && !tx_rate_out)) else $error("3g format");
endmodule
bind sdi_chan_ctrl sdi_chan_ctrl_checker i_chk (.clk_in(clk_in), .reset_in(reset_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .tx_mode_out(tx_mode_out), .tx_rate_out(tx_rate_out),
   .tx_fmt_out(tx_fmt_out), .tx_pattern_out(tx_pattern_out),
   .tx_drive_en_out(tx_drive_en_out), .rx_enable_out(rx_enable_out),
   .channel_pll_reset_out(channel_pll_reset_out), .tx_unit_reset_out(tx_unit_reset_out));

// [sdi_far_model.sv]
/* transceiver reset controller model: reports done or fail after resets.
   assumes reset pulses from the block under test. */
`timescale 1ns/1ps
module sdi_far_model
#(
   parameter DELAY = 6
)
(
   input  wire       clk_in,
   input  wire       pll_rst_in,
   input  wire       unit_rst_in,
   input  wire       fail_sel_in,
   input  wire [2:0] code_sel_in,
   output reg        done_out,
   output reg        fail_out,
   output reg  [2:0] code_out
);
   integer cnt = 0;
   reg     busy = 1'b0;
   initial
   begin
      done_out = 1'b0;
      fail_out = 1'b0;
      code_out = 3'h0;
   end
   always @(posedge clk_in)
   begin
      if (pll_rst_in || unit_rst_in)
      begin
         done_out <= 1'b0;
         fail_out <= 1'b0;
         code_out <= ~code_out;
         busy     <= 1'b1;
         cnt      <= 0;
      end
      else if (busy)
      begin
         cnt <= cnt + 1;
         if (cnt == DELAY)
         begin
            busy     <= 1'b0;
            done_out <= !fail_sel_in;
            fail_out <= fail_sel_in;
            code_out <= code_sel_in;
         end
      end
   end
endmodule

// [tb_top.sv]
/* self-checking bench for sdi_chan_ctrl.
   assumes sdi_far_model answers the reset requests. */
`timescale 1ns/1ps
`include "sdi_ctrl_defs.vh"
module tb_top;
   reg         clk = 0, rst = 1, wr = 0, rd = 0, lk = 0, rr = 0, crc = 0, fs = 0;
   reg  [7:0]  addr = 8'h0;
   reg  [31:0] wdata = 32'h0, d;
   reg  [1:0]  sig = 2'h0, m, p, em = 0, ep = 0;
   reg  [3:0]  xf = 4'h0, xr = 4'h0;
   reg  [2:0]  fc = 3'h0, f, ef = 0;
   reg         r, dv, er = 0, rd_seen = 0, pv = 1;
   wire [31:0] rdata;
   wire [1:0]  mode, pat;
   wire [2:0]  fmt, code;
   wire        irq, rate, drv, rxen, pllr, unitr, done, fail;
   integer     n_fail = 0, checks_done = 0, cyc = 0, i, n;
   reg  [31:0] eq[$], mq[$];
   sdi_chan_ctrl i_dut (.clk_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .tx_mode_out(mode),
      .tx_rate_out(rate), .tx_fmt_out(fmt), .tx_pattern_out(pat), .tx_drive_en_out(drv),
      .rx_enable_out(rxen), .channel_pll_reset_out(pllr), .tx_unit_reset_out(unitr),
      .tx_change_done_in(done), .tx_change_fail_in(fail), .tx_fail_code_in(code),
      .rx_locked_in(lk), .rx_sig_type_in(sig), .rx_rate_in(rr), .rx_xport_fmt_in(xf),
      .rx_xport_rate_in(xr), .rx_crc_err_in(crc));
   sdi_far_model i_far (.clk_in(clk), .pll_rst_in(pllr), .unit_rst_in(unitr),
      .fail_sel_in(fs), .code_sel_in(fc), .done_out(done), .fail_out(fail), .code_out(code));
   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task final_report;
   begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task cmp(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
   begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
         n_fail = n_fail + 1;
         $display("mismatch %0s exp %h got %h", nm, e, g);
      end
   end
   endtask
   task wt(input integer k);
   begin
      repeat (k) @(posedge clk);
      #1;
   end
   endtask
   task wr32(input [7:0] a, input [31:0] v);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   end
   endtask
   task rd32(input [7:0] a, input [31:0] e, input [31:0] k);
   begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      eq.push_back(e);
      mq.push_back(k);
      @(posedge clk);
      rd <= 1'b0;
   end
   endtask
   task err(input integer k);
   begin
      @(posedge clk);
      crc <= 1'b1;
      repeat (k) @(posedge clk);
      crc <= 1'b0;
   end
   endtask
   function ok(input [1:0] mm, input q, input [2:0] ff);
      case (mm)
         2'h0: ok = !q || ff == 3'h1 || ff == 3'h2 || ff == 3'h4 || ff[2:1] == 2'h3;
         2'h1: ok = 1'b1;
         2'h2: ok = ff == 3'h4 || (ff == 3'h5 && !q);
         default: ok = 1'b0;
      endcase
   endfunction
   // read data checker: one queued note per read strobe
   always @(posedge clk)
   begin
      if (rd_seen)
         cmp("rdata", eq.pop_front(), rdata & mq.pop_front());
      rd_seen <= rd;
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h3a090dbb));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      wt(1);
      cmp("txout", 32'h0, {mode, rate, fmt, pat, drv});
      cmp("rxen", 32'h1, rxen);
      rd32(`REG_TX_CTRL, `TXC_RESET, 32'hffffffff);
      rd32(`REG_IRQ_MASK, 32'h0, 32'hf);
      rd32(8'h1c, 32'h0, 32'hffffffff);
      $display("test reset done");
      for (i = 0; i < 64; i = i + 1)
      begin
         m = i[5:4];
         r = i[3];
         f = i[2:0];
         p = $urandom;
         dv = $urandom;
         d = 32'h0;
         d[2:0] = f;
         d[5:4] = p;
         d[8] = r;
         d[13:12] = m;
         d[16] = dv;
         wr32(`REG_TX_CTRL, d);
         if (ok(m, r, f))
         begin
            em = m;
            er = r;
            ef = f;
            ep = m == `MODE_SD ? (p[0] ? `PAT_CHECKFIELD : `PAT_BARS_SD)
               : (p == 2'h3 ? `PAT_CHECKFIELD : p);
         end
         wt(3);
         cmp("txout", {em, er, ef, ep, dv}, {mode, rate, fmt, pat, drv});
         if (!ok(m, r, f))
         begin
            // only entering an invalid combination raises the event
            rd32(`REG_IRQ_STATUS, {29'h0, pv, 2'h0}, 32'h4);
            wr32(`REG_IRQ_STATUS, 32'h4);
            wt(2);
            cmp("irq", 32'h0, irq);
            rd32(`REG_IRQ_STATUS, 32'h0, 32'h4);
         end
         pv = ok(m, r, f);
      end
      $display("test format done");
      wr32(`REG_IRQ_MASK, 32'h4);
      wr32(`REG_TX_CTRL, 32'h0);
      wr32(`REG_TX_CTRL, 32'h3000);
      wt(4);
      cmp("irq", 32'h1, irq);
      wr32(`REG_IRQ_STATUS, 32'h4);
      wt(3);
      cmp("irq", 32'h0, irq);
      $display("test irq done");
      wr32(`REG_RESET_REQ, 32'h1);
      wt(3);
      cmp("rstout", 32'h3, {pllr, unitr});
      n = 0;
      while (pllr === 1'b1 && n < 40)
      begin
         wt(1);
         n = n + 1;
      end
      cmp("pulse", 32'h1, n > 14 && n < 18);
      wt(12);
      rd32(`REG_TX_STATUS, 32'h1, 32'h3);
      @(posedge clk);
      fs <= 1'b1;
      fc <= $urandom;
      wr32(`REG_RESET_REQ, 32'h2);
      wt(3);
      cmp("rstout", 32'h1, {pllr, unitr});
      wt(40);
      rd32(`REG_TX_STATUS, {27'h0, fc, 2'h2}, 32'h1f);
      rd32(`REG_IRQ_STATUS, 32'h3, 32'hf);
      $display("test txreset done");
      for (i = 0; i < 4; i = i + 1)
      begin
         @(posedge clk);
         lk <= 1'b1;
         sig <= i;
         xf <= $urandom;
         xr <= $urandom;
         wt(5);
         rd32(`REG_RX_STATUS, {16'h0, xr, xf, 3'h0, rr, sig, 1'b0, lk}, 32'hff1d);
      end
      @(posedge clk);
      lk <= 1'b0;
      wt(5);
      rd32(`REG_IRQ_STATUS, 32'h8, 32'h8);
      $display("test rxstat done");
      wr32(`REG_RESET_REQ, 32'h4);
      err(3);
      wt(5);
      rd32(`REG_RX_ERRCNT, 32'h3, 32'hffff);
      wr32(`REG_RESET_REQ, 32'h4);
      wt(3);
      rd32(`REG_RX_ERRCNT, 32'h0, 32'hffff);
      err(2);
      @(posedge clk);
      rr <= !rr;
      wt(8);
      rd32(`REG_RX_ERRCNT, 32'h0, 32'hffff);
      wt(2);
      $display("test errcnt done");
      final_report;
   end
endmodule
